// *** rtl/stlog_pkg.sv ***
// Constants shared by the self-test log and log command block.
// Assumes byte-wide log reads and a 200 MHz device clock.
package stlog_pkg;
  localparam int          STLOG_SECTOR_BYTES = 512;
  localparam int          STLOG_DESC_BYTES   = 26;
  localparam int          STLOG_DESC_SLOTS   = 18;
  localparam logic [8:0]  STLOG_DESC_BASE    = 9'h004;
  localparam logic [8:0]  STLOG_DESC_END     = 9'h1d7;
  localparam logic [8:0]  STLOG_REV_ADDR     = 9'h000;
  localparam logic [8:0]  STLOG_IDXL_ADDR    = 9'h002;
  localparam logic [8:0]  STLOG_IDXH_ADDR    = 9'h003;
  localparam logic [8:0]  STLOG_CSUM_ADDR    = 9'h1ff;
  localparam logic [7:0]  STLOG_REVISION     = 8'h01;
  // Field offsets inside one descriptor
  localparam logic [4:0]  STLOG_F_LBALO  = 5'h00;
  localparam logic [4:0]  STLOG_F_STAT   = 5'h01;
  localparam logic [4:0]  STLOG_F_TSLO   = 5'h02;
  localparam logic [4:0]  STLOG_F_TSHI   = 5'h03;
  localparam logic [4:0]  STLOG_F_CHKPT  = 5'h04;
  localparam logic [4:0]  STLOG_F_FLBA0  = 5'h05;
  localparam logic [4:0]  STLOG_F_FLBA5  = 5'h0a;
  // Command opcodes and subcommands
  localparam logic [7:0]  STLOG_OP_WRLOG = 8'h3f;
  localparam logic [7:0]  STLOG_OP_DCFG  = 8'hb1;
  localparam logic [7:0]  STLOG_DC_RESTORE = 8'hc0;
  localparam logic [7:0]  STLOG_DC_FREEZE  = 8'hc1;
  localparam logic [7:0]  STLOG_DC_IDENT   = 8'hc2;
  localparam logic [7:0]  STLOG_DC_SET     = 8'hc3;
  // APB map
  localparam logic [7:0]  STLOG_A_CTRL    = 8'h00;
  localparam logic [7:0]  STLOG_A_STATUS  = 8'h04;
  localparam logic [7:0]  STLOG_A_ERRCNT  = 8'h08;
  localparam logic [7:0]  STLOG_A_POH     = 8'h0c;
  localparam logic [7:0]  STLOG_A_LOGADDR = 8'h10;
  localparam logic [7:0]  STLOG_A_LOGDATA = 8'h14;
  localparam logic [7:0]  STLOG_A_WLPROG  = 8'h18;
  // CTRL bits (write 1 to act)
  localparam int          STLOG_C_WLBLK   = 0;
  localparam int          STLOG_C_DEVERR  = 1;
  localparam int          STLOG_C_HOSTERR = 2;

  typedef enum logic [2:0] {
    STLOG_WL_IDLE = 3'b001,
    STLOG_WL_DATA = 3'b010,
    STLOG_WL_DONE = 3'b100
  } stlog_wl_t;
endpackage : stlog_pkg

// *** rtl/stlog_top.sv ***
// Extended self-test log store, device error counter, Write Log EXT
// block sequencing and Device Configuration subcommand decode.
// Assumes a synchronous taskfile command strobe and an APB master.
`timescale 1ns/1ps

// How it works
// - Device errors count up, saturating at maximum
// - Host-caused errors never touch the counter
// - Byte 511 holds negated sum of bytes 0-510
// - Log is one sector, any addressing mode
// - Byte 0 revision, bytes 2-3 descriptor index
// - 26-byte descriptors packed from byte 4
// - Nineteenth result overwrites slot one, circularly
// - Unused descriptor slots read as zero
// - Index names newest entry, zero to eighteen
// - Revision byte always reads one
// - Descriptor layout: LBA, status, time, checkpoint, LBA
// - LBA Low captured when test issued
// - Status captured when test finished
// - Timestamp is power-on hours at completion
// - Failing LBA is first bad sector seen
// - 28-bit entries also logged in extended log
// - Write Log EXT takes address, offset, count
// - Interrupt after each received data block
// - Feature C0h-C3h selects configuration subcommand
// - Freeze lock aborts later configuration until power-off
module stlog_top
  import stlog_pkg::*;
#(
  parameter int ERRCNT_W = 16
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        POWER_ON_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Taskfile command
  input  wire logic        CMD_STROBE,
  input  wire logic [7:0]  CMD_OPCODE,
  input  wire logic [7:0]  CMD_FEATURE,
  input  wire logic [15:0] CMD_SECCNT,
  input  wire logic [15:0] CMD_LBAMID,
  input  wire logic [7:0]  CMD_LBALO,
  output logic             CMD_ABORT,
  output logic             CMD_DONE,
  output logic             DRQ_INTRQ,
  output logic [3:0]       DCFG_SUBCMD,
  output logic             DCFG_FROZEN,
  // Self-test engine
  input  wire logic        ST_START,
  input  wire logic        ST_FINISH,
  input  wire logic [7:0]  ST_STATUS,
  input  wire logic [7:0]  ST_CHKPT,
  input  wire logic        ST_BADSEC,
  input  wire logic [47:0] ST_BADLBA
);
  localparam int SLOT_W = 5;
  localparam logic [SLOT_W-1:0] LAST_SLOT = SLOT_W'(STLOG_DESC_SLOTS);

  initial begin
    if (ERRCNT_W < 1 || ERRCNT_W > 32) begin
      $error("ERRCNT_W out of range");
    end
    // The slot number must hold every index from zero to the last slot
    if (STLOG_DESC_SLOTS >= (1 << SLOT_W)) begin
      $error("slot index too narrow");
    end
    // Descriptors may not run into the vendor bytes or the checksum
    if (int'(STLOG_DESC_BASE) + STLOG_DESC_SLOTS * STLOG_DESC_BYTES - 1
        != int'(STLOG_DESC_END)) begin
      $error("descriptor area misplaced");
    end
  end

  // Descriptor storage, one flat byte array for the whole area
  logic [7:0]          desc_q [STLOG_DESC_SLOTS*STLOG_DESC_BYTES];
  logic [SLOT_W-1:0]   idx_q;
  logic [7:0]          lbalo_q;
  logic [47:0]         badlba_q;
  logic                badseen_q;
  logic                running_q;
  logic [ERRCNT_W-1:0] errcnt_q;
  logic [15:0]         poh_q;
  logic [8:0]          logaddr_q;
  logic [7:0]          csum_q;
  logic [7:0]          sum_q;
  logic [8:0]          walk_q;
  logic                walking_q;
  logic                frozen_q;
  stlog_wl_t           wl_q;
  logic [15:0]         wl_left_q;
  logic [7:0]          wl_log_q;
  logic [15:0]         wl_off_q;

  wire wr_en = PSEL && PENABLE && PWRITE;
  wire rd_en = PSEL && PENABLE && !PWRITE;

  function automatic logic [7:0] log_byte(input logic [8:0] a);
    logic [8:0] rel;
    rel = a - STLOG_DESC_BASE;
    if (a == STLOG_REV_ADDR) begin
      log_byte = STLOG_REVISION;
    end else if (a == STLOG_IDXL_ADDR) begin
      log_byte = 8'(idx_q);
    end else if (a == STLOG_IDXH_ADDR) begin
      // Index never exceeds eighteen, so the high byte stays zero
      log_byte = 8'h00;
    end else if (a >= STLOG_DESC_BASE && a <= STLOG_DESC_END) begin
      log_byte = desc_q[rel];
    end else if (a == STLOG_CSUM_ADDR) begin
      log_byte = csum_q;
    end else begin
      // Vendor and reserved bytes read as zero
      log_byte = 8'h00;
    end
  endfunction : log_byte

  // Register map decode, shared so that reads and writes of holes agree
  function automatic logic is_mapped(input logic [7:0] a);
    if (a == STLOG_A_CTRL) begin
      is_mapped = 1'b1;
    end else if (a == STLOG_A_STATUS) begin
      is_mapped = 1'b1;
    end else if (a == STLOG_A_ERRCNT) begin
      is_mapped = 1'b1;
    end else if (a == STLOG_A_POH) begin
      is_mapped = 1'b1;
    end else if (a == STLOG_A_LOGADDR) begin
      is_mapped = 1'b1;
    end else if (a == STLOG_A_LOGDATA) begin
      is_mapped = 1'b1;
    end else if (a == STLOG_A_WLPROG) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction : is_mapped

  // Self-test capture; slot advance wraps after the eighteenth
  wire [SLOT_W-1:0] next_idx = (idx_q == LAST_SLOT) ? SLOT_W'(1)
                                                     : idx_q + SLOT_W'(1);
  wire [8:0] slot_base = 9'((next_idx - SLOT_W'(1)) * STLOG_DESC_BYTES);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      running_q <= 1'b0;
      lbalo_q   <= 8'h00;
      badseen_q <= 1'b0;
      badlba_q  <= 48'h0;
    end else if (ST_START) begin
      running_q <= 1'b1;
      lbalo_q   <= CMD_LBALO;
      badseen_q <= 1'b0;
    end else if (running_q) begin
      if (ST_BADSEC && !badseen_q) begin
        badseen_q <= 1'b1;
        badlba_q  <= ST_BADLBA;
      end
      if (ST_FINISH) running_q <= 1'b0;
    end
  end

  // Zeroed at reset, so empty slots read as zero until used
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      idx_q <= '0;
      for (int i = 0; i < STLOG_DESC_SLOTS*STLOG_DESC_BYTES; i++)
        desc_q[i] <= 8'h00;
    end else if (running_q && ST_FINISH) begin
      // Both 28-bit and 48-bit tests land here alike
      idx_q <= next_idx;
      for (int f = 0; f < STLOG_DESC_BYTES; f++)
        desc_q[slot_base + 9'(f)] <= 8'h00;
      desc_q[slot_base + 9'(STLOG_F_LBALO)] <= lbalo_q;
      desc_q[slot_base + 9'(STLOG_F_STAT)]  <= ST_STATUS;
      desc_q[slot_base + 9'(STLOG_F_TSLO)]  <= poh_q[7:0];
      desc_q[slot_base + 9'(STLOG_F_TSHI)]  <= poh_q[15:8];
      desc_q[slot_base + 9'(STLOG_F_CHKPT)] <= ST_CHKPT;
      for (int b = 0; b < 6; b++)
        desc_q[slot_base + 9'(STLOG_F_FLBA0) + 9'(b)] <=
          ST_BADSEC && !badseen_q ? ST_BADLBA[8*b +: 8]
                                  : badlba_q[8*b +: 8];
    end
  end

  // Checksum walker; restarts on every log update
  wire log_upd = running_q && ST_FINISH;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      walking_q <= 1'b1;
      walk_q    <= 9'h000;
      sum_q     <= 8'h00;
      csum_q    <= 8'h00;
    end else if (log_upd) begin
      walking_q <= 1'b1;
      walk_q    <= 9'h000;
      sum_q     <= 8'h00;
    end else if (walking_q) begin
      if (walk_q == STLOG_CSUM_ADDR) begin
        walking_q <= 1'b0;
        csum_q    <= 8'h00 - sum_q;
      end else begin
        sum_q  <= sum_q + log_byte(walk_q);
        walk_q <= walk_q + 9'h001;
      end
    end
  end

  // Error counter and power-on hours (software advances hours)
  wire [31:0] ctrl_w = (wr_en && PADDR == STLOG_A_CTRL) ? PWDATA : 32'h0;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      errcnt_q <= '0;
    end else if (ctrl_w[STLOG_C_DEVERR] && errcnt_q != '1) begin
      errcnt_q <= errcnt_q + 1'b1;
    end
    // Host-caused error pulses fall through without counting
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      poh_q <= 16'h0000;
    end else if (wr_en && PADDR == STLOG_A_POH) begin
      poh_q <= PWDATA[15:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      logaddr_q <= 9'h000;
    end else if (wr_en && PADDR == STLOG_A_LOGADDR) begin
      logaddr_q <= PWDATA[8:0];
    end
  end

  // Lock survives RESET_N; only the power-on reset clears it
  wire cmd_dcfg = CMD_STROBE && CMD_OPCODE == STLOG_OP_DCFG;
  wire dc_known = CMD_FEATURE >= STLOG_DC_RESTORE &&
                  CMD_FEATURE <= STLOG_DC_SET;
  always_ff @(posedge CLK or negedge POWER_ON_N) begin
    if (!POWER_ON_N) begin
      frozen_q <= 1'b0;
    end else if (cmd_dcfg && !frozen_q && CMD_FEATURE == STLOG_DC_FREEZE)
    begin
      frozen_q <= 1'b1;
    end
  end

  // Write Log EXT block sequencing
  wire cmd_wl = CMD_STROBE && CMD_OPCODE == STLOG_OP_WRLOG;
  wire blk_in = ctrl_w[STLOG_C_WLBLK] && wl_q == STLOG_WL_DATA;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wl_q      <= STLOG_WL_IDLE;
      wl_left_q <= 16'h0000;
      wl_log_q  <= 8'h00;
      wl_off_q  <= 16'h0000;
    end else begin
      case (wl_q)
        STLOG_WL_IDLE: begin
          if (cmd_wl && CMD_SECCNT != 16'h0000) begin
            wl_q      <= STLOG_WL_DATA;
            wl_left_q <= CMD_SECCNT;
            wl_log_q  <= CMD_LBALO;
            wl_off_q  <= CMD_LBAMID;
          end
        end
        STLOG_WL_DATA: begin
          if (blk_in) begin
            wl_left_q <= wl_left_q - 16'h0001;
            wl_off_q  <= wl_off_q + 16'h0001;
            if (wl_left_q == 16'h0001) wl_q <= STLOG_WL_DONE;
          end
        end
        STLOG_WL_DONE: wl_q <= STLOG_WL_IDLE;
        default: wl_q <= STLOG_WL_IDLE;
      endcase
    end
  end

  // Command outcome pulses
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CMD_ABORT   <= 1'b0;
      CMD_DONE    <= 1'b0;
      DRQ_INTRQ   <= 1'b0;
      DCFG_SUBCMD <= 4'h0;
    end else begin
      DRQ_INTRQ   <= blk_in;
      CMD_ABORT   <= (cmd_dcfg && (frozen_q || !dc_known))
                   || (cmd_wl && CMD_SECCNT == 16'h0000);
      CMD_DONE    <= (cmd_dcfg && !frozen_q && dc_known)
                   || wl_q == STLOG_WL_DONE;
      DCFG_SUBCMD <= (cmd_dcfg && !frozen_q && dc_known)
                   ? 4'(4'h1 << CMD_FEATURE[1:0]) : 4'h0;
    end
  end
  assign DCFG_FROZEN = frozen_q;

  // APB read path, zero wait states
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      // Latched in setup so the access phase never waits
      if (PADDR == STLOG_A_STATUS) begin
        PRDATA <= {24'h0, 3'(wl_q), walking_q, 3'h0, frozen_q};
      end else if (PADDR == STLOG_A_ERRCNT) begin
        PRDATA <= 32'(errcnt_q);
      end else if (PADDR == STLOG_A_POH) begin
        PRDATA <= {16'h0, poh_q};
      end else if (PADDR == STLOG_A_LOGADDR) begin
        PRDATA <= {23'h0, logaddr_q};
      end else if (PADDR == STLOG_A_LOGDATA) begin
        PRDATA <= {24'h0, log_byte(logaddr_q)};
      end else if (PADDR == STLOG_A_WLPROG) begin
        PRDATA <= {wl_off_q, wl_left_q};
      end else begin
        PRDATA <= 32'h0;
      end
    end
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = (rd_en || wr_en) && !is_mapped(PADDR);
endmodule : stlog_top

// *** dv/stlog_sva.sv ***
// Port checker for stlog_top, bound into every instance.
// Assumes one clock; the freeze lock outlives RESET_N.
`timescale 1ns/1ps
module stlog_sva
  import stlog_pkg::*;
(
  // Clock, resets and APB
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        POWER_ON_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  // Command side
  input wire logic        CMD_STROBE,
  input wire logic [7:0]  CMD_OPCODE,
  input wire logic [7:0]  CMD_FEATURE,
  input wire logic        CMD_ABORT,
  input wire logic        CMD_DONE,
  input wire logic        DRQ_INTRQ,
  input wire logic [3:0]  DCFG_SUBCMD,
  input wire logic        DCFG_FROZEN
);
  logic       dc;
  logic       ok_ft;
  logic       blk_wr;
  logic [3:0] sub_exp;
  assign dc = CMD_STROBE && CMD_OPCODE == STLOG_OP_DCFG;
  assign ok_ft = CMD_FEATURE[7:2] == 6'h30;
  assign blk_wr = PSEL && PENABLE && PWRITE && PADDR == STLOG_A_CTRL
                  && PWDATA[STLOG_C_WLBLK];
  assign sub_exp = 4'h1 << CMD_FEATURE[1:0];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_dcfg_decode: assert property (dc && ok_ft && !DCFG_FROZEN
    |=> CMD_DONE && DCFG_SUBCMD == $past(sub_exp))
    else $error("subcommand decode wrong");
  a_bad_feature: assert property (dc && !ok_ft
    |=> CMD_ABORT && !CMD_DONE) else $error("bad feature not aborted");
  a_frozen_abort: assert property (dc && DCFG_FROZEN
    |=> CMD_ABORT && DCFG_SUBCMD == 4'h0) else $error("lock ignored");
  a_freeze_sets: assert property (dc && ok_ft && !DCFG_FROZEN
    && CMD_FEATURE == STLOG_DC_FREEZE |=> DCFG_FROZEN)
    else $error("freeze lock not set");
  // Only power-on may drop the lock, so RESET_N does not disable this
  a_lock_kept: assert property (@(posedge CLK)
    disable iff (!POWER_ON_N) DCFG_FROZEN |=> DCFG_FROZEN)
    else $error("freeze lock lost");
  a_intrq_cause: assert property (DRQ_INTRQ |-> $past(blk_wr))
    else $error("interrupt without block");
  a_abort_cause: assert property (CMD_ABORT |-> $past(CMD_STROBE))
    else $error("abort without command");
  a_done_pulse: assert property (CMD_DONE |=> !CMD_DONE)
    else $error("done held too long");
  a_sub_onehot: assert property (DCFG_SUBCMD != 4'h0 |->
    $onehot(DCFG_SUBCMD) && CMD_DONE) else $error("subcommand not one-hot");
  c_freeze: cover property (dc && CMD_FEATURE == STLOG_DC_FREEZE);
  c_block: cover property (DRQ_INTRQ);
  c_abort: cover property (CMD_ABORT);
endmodule : stlog_sva

bind stlog_top stlog_sva stlog_sva_i (.*);

// *** dv/stlog_host.sv ***
// Host taskfile model: loads command registers, pulses the strobe.
// Assumes the device answers one edge after taking the strobe.
`timescale 1ns/1ps
module stlog_host (
  // Device side
  input  wire logic   CLK,
  output logic        CMD_STROBE,
  output logic [7:0]  CMD_OPCODE,
  output logic [7:0]  CMD_FEATURE,
  output logic [15:0] CMD_SECCNT,
  output logic [15:0] CMD_LBAMID,
  output logic [7:0]  CMD_LBALO,
  input  wire logic   CMD_ABORT
);
  initial begin
    {CMD_STROBE, CMD_OPCODE, CMD_FEATURE} = '0;
    {CMD_SECCNT, CMD_LBAMID, CMD_LBALO} = '0;
  end
  // Taskfile registers keep their contents after the strobe
  task automatic issue(input logic go, input logic [7:0] op, ft,
    input logic [15:0] cnt, mid, input logic [7:0] lo, output logic ab);
    @(posedge CLK);
    CMD_STROBE <= go;
    CMD_OPCODE <= op;
    CMD_FEATURE <= ft;
    CMD_SECCNT <= cnt;
    CMD_LBAMID <= mid;
    CMD_LBALO <= lo;
    @(posedge CLK);
    CMD_STROBE <= 1'b0;
    @(posedge CLK);
    ab = CMD_ABORT;
  endtask : issue
endmodule : stlog_host

// *** dv/stlog_top_tb.sv ***
// Self-checking bench for stlog_top with its host model.
// Assumes the APB map and latencies of the designer's note.
`timescale 1ns/1ps
module stlog_top_tb;
  import stlog_pkg::*;
  logic        CLK = 1'b0;
  logic        RESET_N, POWER_ON_N, PSEL, PENABLE, PWRITE, PREADY;
  logic        PSLVERR, CMD_STROBE, CMD_ABORT, CMD_DONE, DRQ_INTRQ;
  logic        DCFG_FROZEN, ST_START, ST_FINISH, ST_BADSEC, ab, slv;
  logic [7:0]  PADDR, CMD_OPCODE, CMD_FEATURE, CMD_LBALO, ST_STATUS;
  logic [7:0]  ST_CHKPT;
  logic [15:0] CMD_SECCNT, CMD_LBAMID;
  logic [31:0] PWDATA, PRDATA, seed, rd;
  logic [3:0]  DCFG_SUBCMD, sub_seen;
  logic [47:0] ST_BADLBA;
  logic [87:0] e0, e1, e18, e;
  logic [7:0]  fts [6] = '{8'hc0, 8'hc2, 8'hc3, 8'hc7, 8'h3f, 8'hc1};
  int          num_errors, samples_checked, nirq, ndone;
  stlog_top #(.ERRCNT_W(2)) stlog_top_i (.*);
  stlog_host stlog_host_i (.*);
  always #2.5 CLK = ~CLK;
  always @(negedge CLK) begin
    nirq += int'(DRQ_INTRQ === 1'b1);
    ndone += int'(CMD_DONE === 1'b1);
    if (DCFG_SUBCMD !== 4'h0) sub_seen = DCFG_SUBCMD;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [3:0] exp_sub(input logic [7:0] f);
    return (f[7:2] == 6'h30) ? 4'h1 << f[1:0] : 4'h0;
  endfunction : exp_sub
  task automatic check(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    if (n == 50) begin
      num_errors++;
      summarize();
    end
    {rd, slv} = {PRDATA, PSLVERR};
    {PSEL, PENABLE} <= 2'b00;
  endtask : apb
  task automatic rd_log(input int a, output logic [7:0] b);
    apb(1, STLOG_A_LOGADDR, 32'(a));
    apb(0, STLOG_A_LOGDATA, 0);
    b = rd[7:0];
  endtask : rd_log
  // Bytes from z up to byte 497 must be zero
  task automatic scan_log(input int z, input logic [15:0] idx);
    logic [7:0] b, s;
    s = 8'h00;
    for (int i = 0; i < 511; i++) begin
      rd_log(i, b);
      s += b;
      if (i == 0) check(b, STLOG_REVISION);
      if (i == 2 || i == 3) check(b, idx[8*(i-2) +: 8]);
      if (i >= z && i < 498) check(b, 0);
    end
    rd_log(STLOG_CSUM_ADDR, b);
    s = 8'h00 - s;
    check(b, s);
  endtask : scan_log
  task automatic wait_csum();
    int n;
    repeat (4) @(posedge CLK);
    for (n = 0; n < 1000; n++) begin
      apb(0, STLOG_A_STATUS, 0);
      if (rd[4] === 1'b0) break;
    end
    if (n == 1000) begin
      num_errors++;
      summarize();
    end
  endtask : wait_csum
  task automatic check_desc(input int k, input logic [87:0] x);
    logic [7:0] b;
    for (int j = 0; j < 11; j++) begin
      rd_log(4 + 26 * k + j, b);
      check(b, x[8*j +: 8]);
    end
  endtask : check_desc
  // LBA Low changes and a second bad sector follow the start on purpose
  task automatic selftest(input logic [87:0] x);
    stlog_host_i.issue(0, 0, 0, 0, 0, x[7:0], ab);
    ST_START <= 1'b1;
    @(posedge CLK);
    ST_START <= 1'b0;
    stlog_host_i.issue(0, 0, 0, 0, 0, ~x[7:0], ab);
    apb(1, STLOG_A_POH, 32'(x[31:16]));
    {ST_BADSEC, ST_BADLBA} <= {1'b1, x[87:40]};
    @(posedge CLK);
    ST_BADLBA <= ~x[87:40];
    @(posedge CLK);
    {ST_BADSEC, ST_FINISH, ST_STATUS, ST_CHKPT} <= {2'b01, x[15:8], x[39:32]};
    @(posedge CLK);
    ST_FINISH <= 1'b0;
  endtask : selftest
  initial begin
    {RESET_N, POWER_ON_N, PSEL, PENABLE, PWRITE, ST_START} = '0;
    {ST_FINISH, ST_BADSEC, PADDR, PWDATA, ST_STATUS, ST_CHKPT} = '0;
    {ST_BADLBA, num_errors, samples_checked, nirq, ndone} = '0;
    {seed, sub_seen} = {32'hc3564084, 4'h0};
    repeat (2) @(posedge CLK);
    {RESET_N, POWER_ON_N} <= 2'b11;
    wait_csum();
    scan_log(2, 0);
    apb(0, 8'h1c, 0);
    check({slv, rd}, {1'b1, 32'h0});
    $display("empty log and map done");
    for (int i = 0; i < 7; i++) begin
      apb(1, STLOG_A_CTRL, (i == 1 || i == 3) ? 4 : 2);
      apb(0, STLOG_A_ERRCNT, 0);
      check(rd, (i < 4) ? (i + 2) / 2 : 3);
    end
    $display("error count done");
    for (int i = 0; i < 19; i++) begin
      e = 88'({rnd(), rnd(), rnd()});
      if (i == 0) e[31:16] = 16'hffff;
      selftest(e);
      if (i == 0) wait_csum();
      if (i == 0) check_desc(0, e);
      if (i == 0) scan_log(30, 1);
      e1 = (i == 1) ? e : e1;
    end
    wait_csum();
    check_desc(0, e);
    check_desc(1, e1);
    scan_log(498, 1);
    $display("self-test log done");
    stlog_host_i.issue(1, STLOG_OP_WRLOG, 0, 2, 16'h0102, 8'h80, ab);
    check(ab, 0);
    apb(0, STLOG_A_WLPROG, 0);
    check(rd, 32'h0102_0002);
    repeat (2) apb(1, STLOG_A_CTRL, 1);
    repeat (4) @(posedge CLK);
    check(nirq, 2);
    check(ndone, 1);
    stlog_host_i.issue(1, STLOG_OP_WRLOG, 0, 0, 0, 8'h80, ab);
    check(ab, 1);
    $display("write log done");
    for (int i = 0; i < 6; i++) begin
      stlog_host_i.issue(1, STLOG_OP_DCFG, fts[i], 0, 0, 0, ab);
      check(ab, exp_sub(fts[i]) == 4'h0);
      if (ab === 1'b0) check(sub_seen, exp_sub(fts[i]));
    end
    RESET_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    stlog_host_i.issue(1, STLOG_OP_DCFG, STLOG_DC_IDENT, 0, 0, 0, ab);
    check({DCFG_FROZEN, ab}, 2'b11);
    POWER_ON_N <= 1'b0;
    @(posedge CLK);
    POWER_ON_N <= 1'b1;
    stlog_host_i.issue(1, STLOG_OP_DCFG, STLOG_DC_IDENT, 0, 0, 0, ab);
    check({DCFG_FROZEN, ab}, 2'b00);
    $display("configuration done");
    summarize();
  end
endmodule : stlog_top_tb
